// ---- logic/bct_pkg.sv ----
// Package for the branch condition and return timing block.
// Assumes a single 200 MHz core clock; opcodes arrive one byte per cycle.
package bct_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_JCC_BASE   = 8'h70; // 0111_cccc, one displacement byte
  localparam logic [7:0] OP_LOOP_NZ    = 8'hE0;
  localparam logic [7:0] OP_LOOP_Z     = 8'hE1;
  localparam logic [7:0] OP_LOOP       = 8'hE2;
  localparam logic [7:0] OP_JCOUNT_Z   = 8'hE3;
  localparam logic [7:0] OP_EXIT_NEAR_I = 8'hC2;
  localparam logic [7:0] OP_EXIT_NEAR   = 8'hC3;
  localparam logic [7:0] OP_EXIT_FAR_I  = 8'hCA;
  localparam logic [7:0] OP_EXIT_FAR    = 8'hCB;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [4:0] CYC_JCC_TAKEN  = 5'h08;
  localparam logic [4:0] CYC_JCC_NOT    = 5'h04;
  localparam logic [4:0] CYC_LOOP_TAKEN = 5'h09;
  localparam logic [4:0] CYC_LOOP_NOT   = 5'h05;
  localparam logic [4:0] CYC_LOOPC_TAKEN = 5'h0B;
  localparam logic [4:0] CYC_EXIT_NEAR_I = 5'h0C;
  localparam logic [4:0] CYC_EXIT_FAR_I  = 5'h11;
  localparam logic [4:0] CYC_EXIT_NEAR   = 5'h08;
  localparam logic [4:0] CYC_EXIT_FAR    = 5'h12;

  // Status flags presented by the core
  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic parity_flag;
    logic carry_flag;
  } bct_flags_type;

  // Result of one control-transfer instruction
  typedef struct packed {
    logic        taken;
    logic        is_return;
    logic        far_return;
    logic [15:0] target;     // next ip for jumps, stack adjust for returns
    logic [15:0] count;      // updated count_register
    logic [4:0]  cycles;
  } bct_result_type;

endpackage

// ---- logic/bct_branch_unit.sv ----
// Decode, condition test and cycle timing of the control-transfer group.
// Assumes bytes are presented with byte_valid, one per cycle, opcode first.
// Functional notes
// [RULE_01] Flag-tested jumps: 8 clocks taken, 4 clocks not taken.
// [RULE_02] Plain loop and count-zero jump: 9 taken, 5 not taken.
// [RULE_03] Loop-while-zero and loop-while-nonzero: 11 taken, 5 not taken.
// [RULE_04] Byte 0111_1100 is jump_less, followed by one displacement byte.
// [RULE_05] jump_less when sign differs from overflow; greater_equal when equal.
// [RULE_06] jump_less_equal on zero or sign/overflow differ; jump_greater otherwise.
// [RULE_07] jump_below on carry set; jump_above_equal on carry clear.
// [RULE_08] jump_below_equal on carry or zero; jump_above when both clear.
// [RULE_09] jump_equal on zero set; jump_not_equal on zero clear.
// [RULE_10] jump_parity_even on parity set; jump_parity_odd on parity clear.
// [RULE_11] Above/below compare unsigned; greater/less compare signed.
// [RULE_12] Near exit C2: immediate low byte first added to stack, 12 clocks.
// [RULE_13] Far exit CA: pops offset and segment, adds immediate, 17 clocks.
// [RULE_14] Plain near exit 8 clocks, plain far exit 18, no stack adjust.
// [RULE_15] Overflow and sign jumps test those flags set or clear.
// [RULE_16] Flags untouched; taken target is next ip plus sign-extended displacement.
module bct_branch_unit
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Instruction byte stream
  input  wire logic                    byte_valid,
  input  wire logic [7:0]              byte_data,
  input  wire logic [15:0]             ip_base,
  // Core state
  input  wire bct_pkg::bct_flags_type  flags,
  input  wire logic [15:0]             count_in,
  // Result
  output logic                         done_r,
  output bct_pkg::bct_result_type      result_r,
  output logic                         illegal_r
);

  typedef enum logic [1:0] {S_OPCODE, S_DISP, S_IMM_LO, S_IMM_HI} bct_state_type;

  bct_state_type state_r;
  logic [7:0]    op_r;
  logic [7:0]    imm_lo_r;

  // ----------------------------------------
  // Condition test for 0111_cccc jumps
  // ----------------------------------------
  // Low bit inverts the sense, as in every pair of the group
  function automatic logic jcc_test(input logic [3:0] cc, input bct_pkg::bct_flags_type f);
    logic base;
    base = 1'b0;
    case (cc[3:1])
      3'h0: base = f.overflow_flag;                                 // RULE_15
      3'h1: base = f.carry_flag;                                    // RULE_07
      3'h2: base = f.zero_flag;                                     // RULE_09
      3'h3: base = f.carry_flag | f.zero_flag;                      // RULE_08
      3'h4: base = f.sign_flag;                                     // RULE_15
      3'h5: base = f.parity_flag;                                   // RULE_10
      3'h6: base = f.sign_flag ^ f.overflow_flag;                   // RULE_05
      default: base = (f.sign_flag ^ f.overflow_flag) | f.zero_flag; // RULE_06
    endcase
    return base ^ cc[0]; // RULE_11
  endfunction

  // Next ip after a two-byte branch plus sign-extended displacement
  function automatic logic [15:0] rel_target(input logic [15:0] ip, input logic [7:0] d);
    return 16'(ip + 16'h0002 + {{8{d[7]}}, d}); // RULE_16
  endfunction

  logic [15:0] count_dec;
  logic        loop_go;
  logic        jcc_go;
  assign count_dec = 16'(count_in - 16'h0001);
  assign jcc_go    = jcc_test(op_r[3:0], flags);

  // Loop decision; zero_flag only read, never written
  always_comb
  begin
    case (op_r)
      bct_pkg::OP_LOOP_NZ: loop_go = (count_dec != 16'h0000) & ~flags.zero_flag; // RULE_03
      bct_pkg::OP_LOOP_Z:  loop_go = (count_dec != 16'h0000) & flags.zero_flag;  // RULE_03
      bct_pkg::OP_LOOP:    loop_go = (count_dec != 16'h0000);                    // RULE_02
      default:             loop_go = (count_in == 16'h0000);                     // RULE_02
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r   <= S_OPCODE;
      op_r      <= 8'h00;
      imm_lo_r  <= 8'h00;
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
      result_r  <= '0;
    end
    else
    begin
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
      if (byte_valid)
      begin
        case (state_r)
          S_OPCODE:
          begin
            op_r <= byte_data;
            if (byte_data[7:4] == 4'h7 || (byte_data >= bct_pkg::OP_LOOP_NZ
                && byte_data <= bct_pkg::OP_JCOUNT_Z))
              state_r <= S_DISP; // RULE_04
            else if (byte_data == bct_pkg::OP_EXIT_NEAR_I || byte_data == bct_pkg::OP_EXIT_FAR_I)
              state_r <= S_IMM_LO;
            else if (byte_data == bct_pkg::OP_EXIT_NEAR || byte_data == bct_pkg::OP_EXIT_FAR)
            begin
              done_r              <= 1'b1;
              result_r            <= '0;
              result_r.taken      <= 1'b1;
              result_r.is_return  <= 1'b1;
              result_r.far_return <= byte_data[3];
              result_r.count      <= count_in;
              result_r.cycles     <= byte_data[3] ? bct_pkg::CYC_EXIT_FAR
                                                  : bct_pkg::CYC_EXIT_NEAR; // RULE_14
            end
            else
              illegal_r <= 1'b1;
          end
          S_DISP:
          begin
            state_r         <= S_OPCODE;
            done_r          <= 1'b1;
            result_r        <= '0;
            result_r.count  <= count_in;
            if (op_r[7:4] == 4'h7)
            begin
              result_r.taken  <= jcc_go;
              result_r.target <= jcc_go ? rel_target(ip_base, byte_data) : 16'(ip_base + 16'h0002);
              result_r.cycles <= jcc_go ? bct_pkg::CYC_JCC_TAKEN
                                        : bct_pkg::CYC_JCC_NOT; // RULE_01
            end
            else
            begin
              if (op_r != bct_pkg::OP_JCOUNT_Z)
                result_r.count <= count_dec;
              result_r.taken  <= loop_go;
              result_r.target <= loop_go ? rel_target(ip_base, byte_data)
                                         : 16'(ip_base + 16'h0002);
              if (!loop_go)
                result_r.cycles <= bct_pkg::CYC_LOOP_NOT; // RULE_02
              else if (op_r == bct_pkg::OP_LOOP_NZ || op_r == bct_pkg::OP_LOOP_Z)
                result_r.cycles <= bct_pkg::CYC_LOOPC_TAKEN; // RULE_03
              else
                result_r.cycles <= bct_pkg::CYC_LOOP_TAKEN; // RULE_02
            end
          end
          S_IMM_LO:
          begin
            imm_lo_r <= byte_data; // RULE_12
            state_r  <= S_IMM_HI;
          end
          default:
          begin
            state_r             <= S_OPCODE;
            done_r              <= 1'b1;
            result_r            <= '0;
            result_r.taken      <= 1'b1;
            result_r.is_return  <= 1'b1;
            result_r.far_return <= op_r[3];
            result_r.count      <= count_in;
            result_r.target     <= {byte_data, imm_lo_r}; // RULE_13
            result_r.cycles     <= op_r[3] ? bct_pkg::CYC_EXIT_FAR_I
                                           : bct_pkg::CYC_EXIT_NEAR_I; // RULE_12
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_jcc_cycles: assert property ( // RULE_01
    (byte_valid && state_r == S_DISP && op_r[7:4] == 4'h7) |=> done_r &&
    result_r.cycles == (result_r.taken ? bct_pkg::CYC_JCC_TAKEN : bct_pkg::CYC_JCC_NOT))
    else $error("jump cycle count wrong");
  a_less_cond: assert property ( // RULE_05
    (byte_valid && state_r == S_DISP && op_r == 8'h7C) |=>
    result_r.taken == $past(flags.sign_flag ^ flags.overflow_flag))
    else $error("jump_less condition wrong");
  a_greater_cond: assert property ( // RULE_06
    (byte_valid && state_r == S_DISP && op_r == 8'h7F) |=> result_r.taken ==
    !$past((flags.sign_flag ^ flags.overflow_flag) | flags.zero_flag))
    else $error("jump_greater condition wrong");
  a_below_cond: assert property ( // RULE_07
    (byte_valid && state_r == S_DISP && op_r == 8'h72) |=>
    result_r.taken == $past(flags.carry_flag))
    else $error("jump_below condition wrong");
  a_above_cond: assert property ( // RULE_08
    (byte_valid && state_r == S_DISP && op_r == 8'h77) |=>
    result_r.taken == !$past(flags.carry_flag | flags.zero_flag))
    else $error("jump_above condition wrong");
  a_loop_cycles: assert property ( // RULE_02
    (byte_valid && state_r == S_DISP && (op_r == 8'hE2 || op_r == 8'hE3)) |=>
    result_r.cycles == (result_r.taken ? bct_pkg::CYC_LOOP_TAKEN : bct_pkg::CYC_LOOP_NOT))
    else $error("loop cycle count wrong");
  a_loopc_cycles: assert property ( // RULE_03
    (byte_valid && state_r == S_DISP && (op_r == 8'hE0 || op_r == 8'hE1)) |=>
    result_r.cycles == (result_r.taken ? bct_pkg::CYC_LOOPC_TAKEN : bct_pkg::CYC_LOOP_NOT))
    else $error("conditional loop cycles wrong");
  a_exit_imm: assert property ( // RULE_12
    (byte_valid && state_r == S_OPCODE && byte_data == bct_pkg::OP_EXIT_NEAR_I)
    ##1 byte_valid[*2] |=> done_r && result_r.cycles == bct_pkg::CYC_EXIT_NEAR_I)
    else $error("near exit with immediate wrong");
  a_exit_plain: assert property ( // RULE_14
    (byte_valid && state_r == S_OPCODE && byte_data == bct_pkg::OP_EXIT_FAR) |=>
    done_r && result_r.cycles == bct_pkg::CYC_EXIT_FAR && result_r.target == 16'h0000)
    else $error("plain far exit wrong");

  c_jcc_taken: cover property (done_r && result_r.taken && !result_r.is_return);
  c_loop_fall: cover property (done_r && !result_r.taken && result_r.cycles == 5'h05);
  c_far_imm:   cover property (done_r && result_r.far_return && result_r.cycles == 5'h11);

endmodule

// ---- verification/bct_imem_model.sv ----
// Instruction memory model that feeds opcode and operand bytes.
// Assumes the caller starts send at a falling clock edge.
module bct_imem_model
(
  // Clock
  input  wire logic clk,
  // Byte stream
  output logic       byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Byte driver
  // ----------------------------------------
  initial
  begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // Lowest byte first, so immediates go low then high
  // Idle data flips on each gap cycle and once after the last byte, so a stale byte is never mistaken for a live one
  task automatic send(input logic [23:0] bytes, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      repeat (gap)
      begin
        byte_valid = 1'b0;
        byte_data  = ~byte_data;
        @(negedge clk);
      end
      byte_valid = 1'b1;
      byte_data  = bytes[8*i +: 8];
      @(negedge clk);
    end
    byte_valid = 1'b0;
    byte_data  = ~byte_data;
  endtask
endmodule

// ---- verification/branch_condition_and_return_timing_tb.sv ----
// Self-checking bench for the control-transfer decoder.
// Assumes the memory model drives bytes; the bench drives flags and counts.
module branch_condition_and_return_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   byte_valid, done_r, illegal_r, t;
  logic [7:0]             byte_data, d, o;
  logic [15:0]            ip_base = 16'h0000, count_in = 16'h0000, cnt, nc;
  logic [4:0]             cyc;
  logic [31:0]            seed = 32'h9104;
  bct_pkg::bct_flags_type flags = '0, f;
  bct_pkg::bct_result_type result_r;
  int                     fail_count = 0, comparisons = 0;

  // Clock
  always #2.5 clk = ~clk;

  bct_imem_model u_mem (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));
  bct_branch_unit u_dut (.clk(clk), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .ip_base(ip_base), .flags(flags), .count_in(count_in),
    .done_r(done_r), .result_r(result_r), .illegal_r(illegal_r));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  // Expected decision of a flag-tested jump; odd codes are the complements
  function automatic logic cond(input logic [3:0] c, input bct_pkg::bct_flags_type x);
    logic r;
    case (c[3:1])
      3'h0:    r = x.overflow_flag;
      3'h1:    r = x.carry_flag;
      3'h2:    r = x.zero_flag;
      3'h3:    r = x.carry_flag | x.zero_flag;
      3'h4:    r = x.sign_flag;
      3'h5:    r = x.parity_flag;
      3'h6:    r = x.sign_flag ^ x.overflow_flag;
      default: r = (x.sign_flag ^ x.overflow_flag) | x.zero_flag;
    endcase
    return r ^ c[0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Sends one instruction and waits a bounded time for done or illegal
  task automatic op(input logic [23:0] b, input int n, input logic [15:0] ip,
                    input logic [15:0] c, input bct_pkg::bct_flags_type x, input logic ill);
    int k;
    @(negedge clk);
    ip_base  = ip;
    count_in = c;
    flags    = x;
    seed     = lfsr(seed);
    u_mem.send(b, n, int'(seed[0]));
    k = 0;
    while ((ill ? illegal_r : done_r) !== 1'b1 && k < 8)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check({31'h0, ill ? illegal_r : done_r}, 32'h1);
  endtask

  task automatic expect_res(input logic r, input logic fr, input logic [4:0] cy,
                            input logic [15:0] tg, input logic [15:0] cn);
    check({30'h0, result_r.is_return, result_r.far_return}, {30'h0, r, fr});
    check({27'h0, result_r.cycles}, {27'h0, cy});
    check({result_r.target, result_r.count}, {tg, cn});
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // Every jump code four times with random flags, displacement and address
    for (int i = 0; i < 64; i++)
    begin
      seed = lfsr(seed);
      f    = seed[4:0];
      d    = seed[15:8];
      // The op task advances the seed, so keep the address before calling it
      cnt  = seed[31:16];
      t    = cond(i[3:0], f);
      op({8'h00, d, 4'h7, i[3:0]}, 2, cnt, cnt, f, 1'b0);
      check({31'h0, result_r.taken}, {31'h0, t});
      expect_res(1'b0, 1'b0, t ? 5'h08 : 5'h04, t ? 16'(cnt + 16'h0002 + {{8{d[7]}}, d})
                 : 16'(cnt + 16'h0002), cnt);
    end
    $display("Test jumps done");
    // Loops with counts 0, 1 and 2 under both zero_flag values
    for (int i = 0; i < 24; i++)
    begin
      o   = 8'hE0 + {6'h0, i[1:0]};
      cnt = 16'(i / 8);
      f   = '0;
      f.zero_flag = i[2];
      nc  = (o == 8'hE3) ? cnt : cnt - 16'd1;
      t   = (o == 8'hE3) ? (cnt == 16'h0) : (nc != 16'h0 && (o == 8'hE2 || (o == 8'hE1) == i[2]));
      cyc = t ? (o[1] ? 5'd9 : 5'd11) : 5'd5;
      op({16'h0010, o}, 2, 16'h1000, cnt, f, 1'b0);
      check({31'h0, result_r.taken}, {31'h0, t});
      expect_res(1'b0, 1'b0, cyc, t ? 16'h1012 : 16'h1002, nc);
    end
    $display("Test loops done");
    // Subroutine exits, with and without stack adjustment
    seed = lfsr(seed);
    nc   = seed[15:0];
    op({nc, 8'hC2}, 3, 16'h2000, 16'h0033, '0, 1'b0);
    expect_res(1'b1, 1'b0, 5'h0C, nc, 16'h0033);
    cnt  = seed[23:8];
    op({cnt, 8'hCA}, 3, 16'h2000, 16'h0044, '0, 1'b0);
    expect_res(1'b1, 1'b1, 5'h11, cnt, 16'h0044);
    op({16'h0000, 8'hC3}, 1, 16'h2000, 16'h0055, '0, 1'b0);
    expect_res(1'b1, 1'b0, 5'd8, 16'h0000, 16'h0055);
    op({16'h0000, 8'hCB}, 1, 16'h2000, 16'h0066, '0, 1'b0);
    expect_res(1'b1, 1'b1, 5'd18, 16'h0000, 16'h0066);
    $display("Test returns done");
    // A byte outside the group, then a jump straight after it
    op({16'h0000, 8'h90}, 1, 16'h3000, 16'h0000, '0, 1'b1);
    op({16'h0003, 8'h74}, 2, 16'h3000, 16'h0000, 5'h04, 1'b0);
    expect_res(1'b0, 1'b0, 5'd8, 16'h3005, 16'h0000);
    $display("Test illegal done");
    test_done;
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #20000;
    fail_count++;
    test_done;
  end
endmodule
